// ### hw/dtss_top.sv
`timescale 1ns/1ps
module dtss_top
   import dtss_pkg::*;
(
   input wire logic clk, // 100 MHz clock
   input wire logic nrst, // async reset, active low
   input wire logic wr_en, // parameter write strobe
   input wire logic [2:0] wr_addr, // parameter write address
   input wire logic [31:0] wr_data, // packed write value
   input wire logic [2:0] rd_addr, // parameter read address
   output logic [31:0] rd_data, // read value, registered
   // sources: index 0 power, 1 running, 2 acc power, 3 local kp, 4 remote kp, 5..8 slots
   input wire logic [8:0] src_ok, // clock present per source
   input wire logic [8:0] src_settable, // clock accepts setting
   input wire logic [8:0][4:0] src_dh, // day field
   input wire logic [8:0][3:0] src_mon, // month field
   input wire logic [8:0][6:0] src_yr, // year field
   input wire logic [8:0][4:0] src_hr, // hours
   input wire logic [8:0][5:0] src_min, // minutes
   input wire logic [8:0][5:0] src_sec, // seconds
   input wire logic [8:0][2:0] src_wday, // weekday
   input wire logic drive_reset, // drive reset pulse
   output logic [8:0] rtc_hold, // hold external clocks for setting
   output logic [8:0] rtc_load, // one-cycle load of set value
   output logic [31:0] rtc_date, // date word to load
   output logic [31:0] rtc_time, // time word to load
   output logic [31:0] stamp_date, // date for timers and trips
   output logic [31:0] stamp_time, // time for timers and trips
   output logic timer_repeat_clr, // clear both timer repeat functions
   output logic trip_stamp_clr, // zero all trip dates and times
   output logic [31:0] disp_date // keypad display date word
);
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] sel_reg;
   logic [3:0] stamp_sel_reg;
   logic fmt_reg;
   logic [4:0] d_reg, hr_reg;
   logic [3:0] m_reg;
   logic [6:0] y_reg;
   logic [5:0] mi_reg, s_reg;
   logic [31:0] rd_next;
   logic [31:0] date_word, time_word, disp_next, stamp_d_next, stamp_t_next;
   logic load_pend_reg;

   // refuse a package whose source count no longer fits the selector range
   if (DTSS_SEL_MAX - DTSS_SEL_POWER + 4'h1 != 4'(DTSS_NSRC + 3))
   begin : g_src_check
      $error("source count does not match selector range");
   end

   // selected source index, source ok
   wire [3:0] cur_idx = sel_reg - DTSS_SEL_POWER;
   wire cur_is_rtc = sel_reg >= DTSS_SEL_LKP;
   wire cur_valid = (sel_reg != DTSS_SEL_SET) && src_ok[cur_idx];
   wire [3:0] st_idx = stamp_sel_reg - DTSS_SEL_POWER;
   wire st_valid = (stamp_sel_reg != DTSS_SEL_SET) && src_ok[st_idx];

   // copy source on entering set mode: keypad first, then lowest slot
   logic [3:0] pick_idx;
   logic pick_ok;
   always_comb
   begin
      pick_idx = 4'h3;
      pick_ok = 1'b0;
      for (int i = 8; i >= 3; i--)
      begin
         if (src_ok[i])
         begin
            pick_idx = 4'(i);
            pick_ok = 1'b1;
         end
      end
   end

   wire wr_sel = wr_en && wr_addr == DTSS_ADDR_SEL && wr_data[3:0] <= DTSS_SEL_MAX;
   wire [3:0] new_sel = wr_data[3:0];
   wire entering_set = wr_sel && new_sel == DTSS_SEL_SET && sel_reg != DTSS_SEL_SET;
   wire set_mode = sel_reg == DTSS_SEL_SET;
   wire wr_date = wr_en && set_mode && wr_addr == DTSS_ADDR_DATE;
   wire wr_time = wr_en && set_mode && wr_addr == DTSS_ADDR_TIME;
   wire pending = stamp_sel_reg != sel_reg;
   wire [4:0] pick_hr = src_hr[pick_idx];

   ////////////////////////////////////////////////////////////////////////
   // user-held date and time values
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         d_reg <= '0;
         m_reg <= '0;
         y_reg <= '0;
         hr_reg <= '0;
         mi_reg <= '0;
         s_reg <= '0;
      end
      else if (entering_set && pick_ok)
      begin
         d_reg <= src_dh[pick_idx];
         m_reg <= src_mon[pick_idx];
         y_reg <= src_yr[pick_idx];
         hr_reg <= src_hr[pick_idx];
         mi_reg <= src_min[pick_idx];
         s_reg <= src_sec[pick_idx];
      end
      else
      begin
         if (wr_date)
         begin
            d_reg <= 5'(wr_data / DTSS_W_HI);
            m_reg <= 4'((wr_data / DTSS_W_MID) % DTSS_W_MID);
            y_reg <= 7'(wr_data % DTSS_W_MID);
         end
         if (wr_time)
         begin
            hr_reg <= 5'(wr_data / DTSS_W_HI);
            mi_reg <= 6'((wr_data / DTSS_W_MID) % DTSS_W_MID);
            s_reg <= 6'(wr_data % DTSS_W_MID);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_reg <= DTSS_SEL_RESET;
         fmt_reg <= DTSS_FMT_RESET;
      end
      else
      begin
         if (wr_sel)
            sel_reg <= new_sel;
         if (wr_en && wr_addr == DTSS_ADDR_FMT)
            fmt_reg <= wr_data[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // current value words ..a missing clock forces zero
   logic [4:0] c_dh, c_hr;
   logic [3:0] c_mon;
   logic [6:0] c_yr;
   logic [5:0] c_min, c_sec;
   always_comb
   begin
      c_dh = set_mode ? d_reg : (cur_valid ? src_dh[cur_idx] : '0);
      c_mon = set_mode ? m_reg : (cur_valid ? src_mon[cur_idx] : '0);
      c_yr = set_mode ? y_reg : (cur_valid ? src_yr[cur_idx] : '0);
      c_hr = set_mode ? hr_reg : (cur_valid ? src_hr[cur_idx] : '0);
      c_min = set_mode ? mi_reg : (cur_valid ? src_min[cur_idx] : '0);
      c_sec = set_mode ? s_reg : (cur_valid ? src_sec[cur_idx] : '0);
   end

   dtss_bcd_word u_date (.hi(c_dh), .mid({2'b00, c_mon}), .lo(c_yr), .word(date_word));
   dtss_bcd_word u_time (.hi(c_hr), .mid(c_min), .lo({1'b0, c_sec}), .word(time_word));
   // keypad swaps day and month only for display
   dtss_bcd_word u_disp (.hi(fmt_reg ? {1'b0, c_mon} : c_dh),
      .mid(fmt_reg ? {1'b0, c_dh} : {2'b00, c_mon}), .lo(c_yr), .word(disp_next));

   logic [4:0] s_dh, s_hr;
   logic [3:0] s_mon;
   logic [6:0] s_yr;
   logic [5:0] s_min, s_sec;
   always_comb
   begin
      s_dh = st_valid ? src_dh[st_idx] : d_reg;
      s_mon = st_valid ? src_mon[st_idx] : m_reg;
      s_yr = st_valid ? src_yr[st_idx] : y_reg;
      s_hr = st_valid ? src_hr[st_idx] : hr_reg;
      s_min = st_valid ? src_min[st_idx] : mi_reg;
      s_sec = st_valid ? src_sec[st_idx] : s_reg;
      if (stamp_sel_reg != DTSS_SEL_SET && !st_valid)
      begin
         s_dh = '0;
         s_mon = '0;
         s_yr = '0;
         s_hr = '0;
         s_min = '0;
         s_sec = '0;
      end
   end
   dtss_bcd_word u_sd (.hi(s_dh), .mid({2'b00, s_mon}), .lo(s_yr), .word(stamp_d_next));
   dtss_bcd_word u_st (.hi(s_hr), .mid(s_min), .lo({1'b0, s_sec}), .word(stamp_t_next));

   wire [2:0] wday = (cur_is_rtc && cur_valid) ? src_wday[cur_idx] : DTSS_SUNDAY;

   // read mux: comms values never depend on the format setting
   always_comb
   begin
      unique case (rd_addr)
         DTSS_ADDR_DATE: rd_next = date_word;
         DTSS_ADDR_TIME: rd_next = time_word;
         DTSS_ADDR_WDAY: rd_next = {29'h0, wday};
         DTSS_ADDR_SEL: rd_next = {28'h0, sel_reg};
         DTSS_ADDR_FMT: rd_next = {31'h0, fmt_reg};
         default: rd_next = 32'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // stamp source latched only by drive reset; a change clears timers and trips
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stamp_sel_reg <= DTSS_SEL_RESET;
         timer_repeat_clr <= 1'b0;
         trip_stamp_clr <= 1'b0;
      end
      else
      begin
         timer_repeat_clr <= drive_reset && pending;
         trip_stamp_clr <= drive_reset && pending;
         if (drive_reset)
            stamp_sel_reg <= sel_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external clock control; hold frees when selector leaves set mode
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rtc_hold <= '0;
         load_pend_reg <= 1'b0;
         rtc_load <= '0;
         rtc_date <= '0;
         rtc_time <= '0;
         rd_data <= '0;
         stamp_date <= '0;
         stamp_time <= '0;
         disp_date <= '0;
      end
      else
      begin
         rtc_hold <= set_mode ? (src_ok & src_settable & DTSS_EXT_MASK) : 9'h000;
         // load waits a cycle so the words already carry the value just written
         load_pend_reg <= wr_date || wr_time;
         rtc_load <= load_pend_reg ? (src_ok & src_settable & DTSS_EXT_MASK) : 9'h000;
         rtc_date <= date_word;
         rtc_time <= time_word;
         rd_data <= rd_next;
         stamp_date <= stamp_d_next;
         stamp_time <= stamp_t_next;
         disp_date <= disp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   hold_release_a: assert property (@(posedge clk) disable iff (!nrst)
      (sel_reg != DTSS_SEL_SET) |=> (rtc_hold == 9'h000))
      else $error("clocks held outside set mode");
   stamp_keep_a: assert property (@(posedge clk) disable iff (!nrst)
      !drive_reset |=> $stable(stamp_sel_reg))
      else $error("stamp source moved without drive reset");
   clr_on_reset_a: assert property (@(posedge clk) disable iff (!nrst)
      (drive_reset && pending) |=> (timer_repeat_clr && trip_stamp_clr))
      else $error("timers not cleared on reset after change");
   no_clr_a: assert property (@(posedge clk) disable iff (!nrst)
      !drive_reset |=> !timer_repeat_clr)
      else $error("spurious timer clear");
   wday_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      (!cur_is_rtc && rd_addr == DTSS_ADDR_WDAY) |=> (rd_data == 32'h0))
      else $error("weekday nonzero for non clock source");
   missing_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      (!set_mode && !cur_valid && rd_addr == DTSS_ADDR_TIME) |=> (rd_data == 32'h0))
      else $error("missing clock did not read zero");
   set_load_a: assert property (@(posedge clk) disable iff (!nrst)
      (entering_set && pick_ok) |=> (hr_reg == $past(pick_hr)))
      else $error("set entry did not copy clock");
   no_write_a: assert property (@(posedge clk) disable iff (!nrst)
      (!set_mode && !entering_set) |=> $stable(hr_reg))
      else $error("time changed outside set mode");
   fmt_same_a: assert property (@(posedge clk) disable iff (!nrst)
      (!fmt_reg) |=> (disp_date == $past(date_word)))
      else $error("standard display differs from date word");
   fmt_us_a: assert property (@(posedge clk) disable iff (!nrst)
      fmt_reg |=> (disp_date / DTSS_W_HI == 32'($past(c_mon))))
      else $error("US display does not lead with month");
endmodule // dtss_top

// ### hw/dtss_pkg.sv
package dtss_pkg;
   localparam logic [3:0] DTSS_SEL_SET = 4'h0;
   localparam logic [3:0] DTSS_SEL_POWER = 4'h1;
   localparam logic [3:0] DTSS_SEL_RUN = 4'h2;
   localparam logic [3:0] DTSS_SEL_ACC = 4'h3;
   localparam logic [3:0] DTSS_SEL_LKP = 4'h4;
   localparam logic [3:0] DTSS_SEL_RKP = 4'h5;
   localparam logic [3:0] DTSS_SEL_SLOT1 = 4'h6;
   localparam logic [3:0] DTSS_SEL_MAX = 4'h9;
   localparam logic [3:0] DTSS_SEL_RESET = 4'h1;
   localparam logic DTSS_FMT_RESET = 1'b0;
   // register addresses on the parameter port
   localparam logic [2:0] DTSS_ADDR_DATE = 3'h0;
   localparam logic [2:0] DTSS_ADDR_TIME = 3'h1;
   localparam logic [2:0] DTSS_ADDR_WDAY = 3'h2;
   localparam logic [2:0] DTSS_ADDR_SEL = 3'h3;
   localparam logic [2:0] DTSS_ADDR_FMT = 3'h4;
   localparam logic [31:0] DTSS_W_HI = 32'h0000_2710;
   localparam logic [31:0] DTSS_W_MID = 32'h0000_0064;
   localparam logic [2:0] DTSS_SUNDAY = 3'h0;
   // keypads and option slots; the internal timers are never held or loaded
   localparam logic [8:0] DTSS_EXT_MASK = 9'h1f8;
   localparam int DTSS_NSRC = 6;
endpackage

// ### hw/dtss_bcd_word.sv
`timescale 1ns/1ps
// packs three decimal fields into one word: hi*10000 + mid*100 + lo
module dtss_bcd_word
   import dtss_pkg::*;
(
   input wire logic [4:0] hi, // hours or day
   input wire logic [5:0] mid, // minutes or month
   input wire logic [6:0] lo, // seconds or year
   output logic [31:0] word // packed word
);
   assign word = 32'(hi) * DTSS_W_HI + 32'(mid) * DTSS_W_MID + 32'(lo);
endmodule // dtss_bcd_word

// ### tb/dtss_rtc_model.sv
`timescale 1ns/1ps
module dtss_rtc_model
   import dtss_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic [8:0] rtc_load, // load strobe per clock
   input wire logic [31:0] rtc_date, // date word to load
   input wire logic [31:0] rtc_time, // time word to load
   output logic [8:0] src_settable, // clocks that accept setting
   output logic [8:0][4:0] src_dh, // day
   output logic [8:0][3:0] src_mon, // month
   output logic [8:0][6:0] src_yr, // year
   output logic [8:0][4:0] src_hr, // hours
   output logic [8:0][5:0] src_min, // minutes
   output logic [8:0][5:0] src_sec, // seconds
   output logic [8:0][2:0] src_wday // weekday
);
   // slot 2 refuses setting so a load mask of all ones is caught
   assign src_settable = 9'h1bf;
   always_ff @(posedge clk or negedge nrst)
   begin
      for (int i = 0; i < 9; i++)
      begin
         if (!nrst)
         begin
            src_dh[i] <= 5'(i + 3);
            src_mon[i] <= 4'(i + 1);
            src_yr[i] <= 7'(i + 20);
            src_hr[i] <= 5'(i + 1);
            src_min[i] <= 6'(i + 10);
            src_sec[i] <= 6'(i + 30);
            src_wday[i] <= 3'(i % 7);
         end
         else if (rtc_load[i] && src_settable[i])
         begin
            src_dh[i] <= 5'(rtc_date / 10000);
            src_mon[i] <= 4'(rtc_date / 100 % 100);
            src_yr[i] <= 7'(rtc_date % 100);
            src_hr[i] <= 5'(rtc_time / 10000);
            src_min[i] <= 6'(rtc_time / 100 % 100);
            src_sec[i] <= 6'(rtc_time % 100);
         end
      end
   end
endmodule // dtss_rtc_model

// ### tb/test_date_time_source_select.sv
`timescale 1ns/1ps
module test_date_time_source_select;
   import dtss_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wr_en = 1'b0;
   logic [2:0] wr_addr = 3'h0;
   logic [31:0] wr_data = 32'h0;
   logic [2:0] rd_addr = 3'h0;
   logic drive_reset = 1'b0;
   logic [8:0] present = 9'h1ff;
   logic [31:0] rd_data, rtc_date, rtc_time, stamp_date, stamp_time, disp_date;
   logic [8:0] src_settable, rtc_hold, rtc_load;
   logic [8:0][4:0] src_dh, src_hr;
   logic [8:0][3:0] src_mon;
   logic [8:0][6:0] src_yr;
   logic [8:0][5:0] src_min, src_sec;
   logic [8:0][2:0] src_wday;
   logic timer_repeat_clr, trip_stamp_clr;
   int error_cnt = 0;
   int total_checks = 0;
   always #5 clk = ~clk;
   dtss_top DUT (.clk, .nrst, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data,
      .src_ok(present), .src_settable, .src_dh, .src_mon, .src_yr, .src_hr,
      .src_min, .src_sec, .src_wday, .drive_reset, .rtc_hold, .rtc_load,
      .rtc_date, .rtc_time, .stamp_date, .stamp_time, .timer_repeat_clr,
      .trip_stamp_clr, .disp_date);
   dtss_rtc_model far_clocks (.clk, .nrst, .rtc_load, .rtc_date, .rtc_time,
      .src_settable, .src_dh, .src_mon, .src_yr, .src_hr, .src_min, .src_sec,
      .src_wday);
   ////////////////////////////////////////////////////////////////////////////
   // model clock i: day i+3, month i+1, year i+20, time (i+1):(i+10):(i+30)
   function automatic logic [31:0] dw(input int i);
      return 32'((i + 3) * 10000 + (i + 1) * 100 + i + 20);
   endfunction
   function automatic logic [31:0] tw(input int i);
      return 32'((i + 1) * 10000 + (i + 10) * 100 + i + 30);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   // extra cycle lets a fresh selector reach the value registers
   task automatic rd(input logic [2:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd_addr <= a;
      repeat (2) @(posedge clk);
      #1;
      check(rd_data, exp);
   endtask
   task automatic drst(input logic exp);
      @(posedge clk);
      drive_reset <= 1'b1;
      @(posedge clk);
      drive_reset <= 1'b0;
      #1;
      check({31'h0, timer_repeat_clr}, {31'h0, exp});
      check({31'h0, trip_stamp_clr}, {31'h0, exp});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #50000;
      error_cnt++;
      results;
   end
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(DTSS_ADDR_SEL, 32'h1);
      rd(DTSS_ADDR_FMT, 32'h0);
      rd(DTSS_ADDR_TIME, tw(0));
      $display("reset test done");
      for (int s = 1; s <= 9; s++)
      begin
         wr(DTSS_ADDR_SEL, 32'(s));
         rd(DTSS_ADDR_DATE, dw(s - 1));
         rd(DTSS_ADDR_TIME, tw(s - 1));
         rd(DTSS_ADDR_WDAY, s < 4 ? 32'h0 : 32'((s - 1) % 7));
      end
      @(posedge clk);
      present <= 9'h1b7;
      wr(DTSS_ADDR_SEL, 32'h4);
      rd(DTSS_ADDR_TIME, 32'h0);
      wr(DTSS_ADDR_SEL, 32'h7);
      rd(DTSS_ADDR_DATE, 32'h0);
      wr(DTSS_ADDR_SEL, 32'ha);
      rd(DTSS_ADDR_SEL, 32'h7);
      $display("source test done");
      wr(DTSS_ADDR_SEL, 32'h5);
      wr(DTSS_ADDR_WDAY, 32'h1);
      wr(DTSS_ADDR_DATE, 32'h0000_27db);
      rd(DTSS_ADDR_WDAY, 32'h4);
      rd(DTSS_ADDR_DATE, dw(4));
      wr(DTSS_ADDR_FMT, 32'h1);
      rd(DTSS_ADDR_DATE, dw(4));
      check(disp_date, 32'h0000_c624);
      wr(DTSS_ADDR_FMT, 32'h0);
      rd(DTSS_ADDR_FMT, 32'h0);
      check(disp_date, dw(4));
      $display("write and format test done");
      check(stamp_time, tw(0));
      check(stamp_date, dw(0));
      drst(1'b1);
      drst(1'b0);
      check(stamp_time, tw(4));
      $display("stamp test done");
      @(posedge clk);
      present <= 9'h1e7;
      wr(DTSS_ADDR_SEL, 32'h0);
      rd(DTSS_ADDR_DATE, dw(5));
      check({23'h0, rtc_hold}, 32'h0000_01a0);
      wr(DTSS_ADDR_SEL, 32'h1);
      @(posedge clk);
      present <= 9'h1ff;
      wr(DTSS_ADDR_SEL, 32'h0);
      rd(DTSS_ADDR_DATE, dw(3));
      wr(DTSS_ADDR_TIME, 32'h0001_e240);
      @(posedge clk);
      #1;
      check({23'h0, rtc_load}, 32'h0000_01b8);
      check(rtc_time, 32'h0001_e240);
      wr(DTSS_ADDR_SEL, 32'h6);
      rd(DTSS_ADDR_TIME, 32'h0001_e240);
      check({23'h0, rtc_hold}, 32'h0);
      $display("set mode test done");
      results;
   end
endmodule // test_date_time_source_select
